/* File: rtl/sbsu_regs.vh */
`ifndef SBSU_REGS_VH
`define SBSU_REGS_VH
// ------------------------------------------------------------
// State codes
// ------------------------------------------------------------
`define SBSU_ST_IDLE 4'h0
`define SBSU_ST_ADDR 4'h1
`define SBSU_ST_SINGLE 4'h2
`define SBSU_ST_WFIRST 4'h3
`define SBSU_ST_WSECOND 4'h4
`define SBSU_ST_B1 4'h5
`define SBSU_ST_B8 4'hC
`define SBSU_ST_HOLD 4'hD
// ------------------------------------------------------------
// Access sizes
// ------------------------------------------------------------
`define SBSU_SZ_BYTE 2'h0
`define SBSU_SZ_HALF 2'h1
`define SBSU_SZ_WORD 2'h2
`define SBSU_SZ_BURST 2'h3
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SBSU_RST_STATE 4'h0
`define SBSU_RST_STROBE 1'h1
`define SBSU_RST_CS 4'hF
`define SBSU_RST_BE 2'h3
`endif

/* File: rtl/sbsu_lanes.v */
`timescale 1ns/10ps
`include "sbsu_regs.vh"
// ------------------------------------------------------------
// Byte enables and address line 1 for one transfer
// ------------------------------------------------------------
module sbsu_lanes (
   input wire [1:0] i_size,
   input wire [1:0] i_addr_lo,
   input wire [2:0] i_beat,
   output reg o_a1,
   output reg o_bh_n,
   output reg [1:0] o_be_n
);
   always @* begin
      o_a1 = 1'h0;
      o_bh_n = 1'h1;
      o_be_n = 2'h3;
      case (i_size)
         `SBSU_SZ_BYTE: begin
            o_a1 = i_addr_lo[1];
            o_be_n = i_addr_lo[0] ? 2'h1 : 2'h2;
         end
         `SBSU_SZ_HALF: begin
            o_a1 = i_addr_lo[1];
            o_be_n = 2'h0;
         end
         default: begin
            o_a1 = i_beat[0];
            o_bh_n = 1'h0;
            o_be_n = 2'h0;
         end
      endcase
   end
endmodule // sbsu_lanes

/* File: rtl/sbsu_rdmux.v */
`timescale 1ns/10ps
`include "sbsu_regs.vh"
// ------------------------------------------------------------
// Read data placement into the operand word
// ------------------------------------------------------------
module sbsu_rdmux (
   input wire [1:0] i_size,
   input wire i_addr0,
   input wire i_upper,
   input wire [15:0] i_bus,
   input wire [31:0] i_cur,
   output reg [31:0] o_word
);
   always @* begin
      o_word = i_cur;
      case (i_size)
         `SBSU_SZ_BYTE: o_word = {24'h000000, i_addr0 ? i_bus[15:8] : i_bus[7:0]};
         `SBSU_SZ_HALF: o_word = {16'h0000, i_bus};
         default: begin
            if (i_upper) begin
               o_word = {i_bus, i_cur[15:0]};
            end else begin
               o_word = {i_cur[31:16], i_bus};
            end
         end
      endcase
   end
endmodule // sbsu_rdmux

/* File: rtl/sbsu_top.v */
// Function
// - Width select at reset picks 16-bit path; upper data lines float.
// - Width is latched only in reset and kept afterwards.
// - Lane 3 pin carries address line 1, lane 2 pin the high byte enable.
// - Halfword writes put upper or lower half on lines 0-15.
// - Word access is two transfers, low half first, high half second.
// - Byte/halfword: A1 is address bit 1, high enable off; byte lanes by bit 0, halfword both lanes.
// - Word/burst: all enables on, A1 alternates from 0 per transfer.
// - Byte reads pick bus byte by address bit 0; halfwords fill 15-0.
// - Byte writes drive bits 7-0 on low or high bus byte.
// - Single transfers serve I/O, stores, uncached loads and fetches.
// - Bursts are four words, memory only, 16-byte aligned.
// - Fourteen bus states, all changing on the clock.
// - Idle keeps strobe and selects inactive, samples hold request.
// - Address state asserts strobe; write data only for non-burst writes.
// - After address go single, word-first or burst 1 by size.
// - Single state waits for ready, then captures read data and goes idle, or to address for a pending unlocked write after a write.
// - Word-first waits for ready, then captures the low halfword.
// - Word-second samples hold; a wait discards that sample.
// - Burst states wait, move one word half each, then go idle, or to address for a pending unlocked write after a write.
// - Hold state lasts while hold request stays active.
// - Hold with ready at cycle end goes idle and acknowledges.
`timescale 1ns/10ps
`include "sbsu_regs.vh"
module sbsu_top (
   input wire I_CLK,
   input wire I_RST_B,
   input wire I_WIDTH16,
   input wire I_REQ,
   input wire I_REQ_WRITE,
   input wire [1:0] I_REQ_SIZE,
   input wire I_REQ_IO,
   input wire I_REQ_LOCK,
   input wire [31:0] I_REQ_ADDR,
   input wire [127:0] I_REQ_WDATA,
   input wire [3:0] I_REQ_CS_N,
   input wire I_READY_N,
   input wire I_HOLD_REQ_N,
   input wire [31:0] I_DATA,
   output reg O_REQ_ACK,
   output reg O_RD_VALID,
   output reg [31:0] O_RD_DATA,
   output reg O_REJECT,
   output reg O_WIDTH16,
   output reg [31:0] O_ADDR,
   output reg O_BE0_N,
   output reg O_BE1_N,
   output reg O_BE2_HBE_N,
   output reg O_HALFWORD_ADDRESS_LINE,
   output reg O_CYC_START_N,
   output reg [3:0] O_CS_N,
   output reg O_IO_SPACE,
   output reg O_WRITE,
   output reg [31:0] O_DATA,
   output reg [31:0] O_DATA_OE,
   output reg O_HOLD_ACK_N
);
   // ---------------------------------------------------------
   // State and access registers
   // ---------------------------------------------------------
   reg [3:0] state_ff, nxt_state;
   reg width_ff;
   reg [1:0] size_ff;
   reg write_ff, lock_ff;
   reg [31:0] addr_ff;
   reg [127:0] wbuf_ff;
   reg [2:0] beat_ff, nxt_beat;
   reg [31:0] word_ff;
   reg hold_seen_ff;
   wire ready = ~I_READY_N;
   wire hold = ~I_HOLD_REQ_N;
   wire req_ok;
   wire lane_a1, lane_bh_n;
   wire [1:0] lane_be_n;
   wire [31:0] rd_word;
   wire in_xfer;
   wire last_beat;
   reg [15:0] wr_half;
   // Address state drives lanes and data before the request fields are registered
   wire take_req = (nxt_state == `SBSU_ST_ADDR);
   wire [1:0] sel_size = take_req ? I_REQ_SIZE : size_ff;
   wire [1:0] sel_addr = take_req ? I_REQ_ADDR[1:0] : addr_ff[1:0];
   wire [127:0] sel_wbuf = take_req ? I_REQ_WDATA : wbuf_ff;
   wire sel_write = take_req ? I_REQ_WRITE : write_ff;

   assign req_ok = (I_REQ_SIZE != `SBSU_SZ_BURST) ||
                   (~I_REQ_IO && (I_REQ_ADDR[3:0] == 4'h0));
   assign in_xfer = (state_ff == `SBSU_ST_SINGLE) || (state_ff == `SBSU_ST_WFIRST) ||
                    (state_ff == `SBSU_ST_WSECOND) ||
                    ((state_ff >= `SBSU_ST_B1) && (state_ff <= `SBSU_ST_B8));
   assign last_beat = (state_ff == `SBSU_ST_SINGLE) || (state_ff == `SBSU_ST_WSECOND) ||
                      (state_ff == `SBSU_ST_B8);

   sbsu_lanes u_lanes (
      .i_size(sel_size),
      .i_addr_lo(sel_addr),
      .i_beat(nxt_beat),
      .o_a1(lane_a1),
      .o_bh_n(lane_bh_n),
      .o_be_n(lane_be_n)
   );

   sbsu_rdmux u_rdmux (
      .i_size(size_ff),
      .i_addr0(addr_ff[0]),
      .i_upper(beat_ff[0]),
      .i_bus(I_DATA[15:0]),
      .i_cur(word_ff),
      .o_word(rd_word)
   );

   // ---------------------------------------------------------
   // Next state
   // ---------------------------------------------------------
   // Fourteen clocked states
   always @* begin
      nxt_state = state_ff;
      nxt_beat = beat_ff;
      case (state_ff)
         `SBSU_ST_IDLE: begin
            if (hold && ~lock_ff) begin
               nxt_state = `SBSU_ST_HOLD;
            end else if (I_REQ && req_ok) begin
               nxt_state = `SBSU_ST_ADDR;
               nxt_beat = 3'h0;
            end
         end
         `SBSU_ST_ADDR: begin
            if (size_ff == `SBSU_SZ_WORD) begin
               nxt_state = `SBSU_ST_WFIRST;
            end else if (size_ff == `SBSU_SZ_BURST) begin
               nxt_state = `SBSU_ST_B1;
            end else begin
               nxt_state = `SBSU_ST_SINGLE;
            end
         end
         `SBSU_ST_WFIRST: begin
            if (ready) begin
               nxt_state = `SBSU_ST_WSECOND;
               nxt_beat = 3'h1;
            end
         end
         `SBSU_ST_HOLD: begin
            if (~hold) begin
               nxt_state = `SBSU_ST_IDLE;
            end
         end
         default: begin
            if (state_ff > `SBSU_ST_B8) begin
               nxt_state = `SBSU_ST_IDLE;
            end else if (ready && ~last_beat) begin
               nxt_state = state_ff + 4'h1;
               nxt_beat = beat_ff + 3'h1;
            end else if (ready) begin
               if (I_REQ && req_ok && I_REQ_WRITE && ~I_REQ_LOCK && ~hold &&
                   write_ff && ~lock_ff) begin
                  nxt_state = `SBSU_ST_ADDR;
               end else begin
                  nxt_state = `SBSU_ST_IDLE;
               end
               nxt_beat = 3'h0;
            end
         end
      endcase
   end

   always @* begin
      wr_half = sel_wbuf[15:0];
      case (sel_size)
         `SBSU_SZ_BYTE: wr_half = sel_addr[0] ? {sel_wbuf[7:0], 8'h00} :
                                                {8'h00, sel_wbuf[7:0]};
         `SBSU_SZ_HALF: wr_half = sel_addr[1] ? sel_wbuf[31:16] : sel_wbuf[15:0];
         default: wr_half = sel_wbuf[{nxt_beat, 4'h0} +: 16];
      endcase
   end

   // ---------------------------------------------------------
   // Registers
   // ---------------------------------------------------------
   always @(posedge I_CLK) begin
      if (~I_RST_B) begin
         state_ff <= `SBSU_RST_STATE;
         width_ff <= I_WIDTH16;
         size_ff <= `SBSU_SZ_BYTE;
         write_ff <= 1'h0;
         lock_ff <= 1'h0;
         addr_ff <= 32'h00000000;
         wbuf_ff <= 128'h0;
         beat_ff <= 3'h0;
         word_ff <= 32'h00000000;
         hold_seen_ff <= 1'h0;
         O_REQ_ACK <= 1'h0;
         O_RD_VALID <= 1'h0;
         O_RD_DATA <= 32'h00000000;
         O_REJECT <= 1'h0;
         O_WIDTH16 <= I_WIDTH16;
         O_ADDR <= 32'h00000000;
         O_BE0_N <= 1'h1;
         O_BE1_N <= 1'h1;
         O_BE2_HBE_N <= 1'h1;
         O_HALFWORD_ADDRESS_LINE <= 1'h1;
         O_CYC_START_N <= `SBSU_RST_STROBE;
         O_CS_N <= `SBSU_RST_CS;
         O_IO_SPACE <= 1'h0;
         O_WRITE <= 1'h0;
         O_DATA <= 32'h00000000;
         O_DATA_OE <= 32'h00000000;
         O_HOLD_ACK_N <= 1'h1;
      end else begin
         state_ff <= nxt_state;
         beat_ff <= nxt_beat;
         O_WIDTH16 <= width_ff;
         O_REQ_ACK <= 1'h0;
         O_RD_VALID <= 1'h0;
         O_REJECT <= 1'h0;
         if (nxt_state == `SBSU_ST_ADDR && state_ff != `SBSU_ST_ADDR) begin
            size_ff <= I_REQ_SIZE;
            write_ff <= I_REQ_WRITE;
            lock_ff <= I_REQ_LOCK;
            addr_ff <= I_REQ_ADDR;
            wbuf_ff <= I_REQ_WDATA;
            word_ff <= 32'h00000000;
            O_REQ_ACK <= 1'h1;
         end else if (state_ff == `SBSU_ST_IDLE && I_REQ && ~req_ok && ~hold) begin
            O_REJECT <= 1'h1;
         end
         if (in_xfer && ready && ~write_ff) begin
            word_ff <= rd_word;
            if (last_beat || (beat_ff[0] && size_ff == `SBSU_SZ_BURST)) begin
               O_RD_VALID <= 1'h1;
               O_RD_DATA <= rd_word;
            end
         end
         if (last_beat) begin
            hold_seen_ff <= hold && ready;
         end else begin
            hold_seen_ff <= 1'h0;
         end
         if (state_ff == `SBSU_ST_IDLE && ~hold && ~lock_ff) begin
            lock_ff <= 1'h0;
         end
         O_HOLD_ACK_N <= ~((hold_seen_ff && state_ff == `SBSU_ST_IDLE) ||
                           (nxt_state == `SBSU_ST_HOLD));
         O_CYC_START_N <= ~(nxt_state == `SBSU_ST_ADDR);
         // Idle and hold keep selects, byte enables and A1 inactive; idle after a write leaves data driven
         if (nxt_state == `SBSU_ST_IDLE || nxt_state == `SBSU_ST_HOLD) begin
            O_CS_N <= `SBSU_RST_CS;
            O_BE0_N <= 1'h1;
            O_BE1_N <= 1'h1;
            O_BE2_HBE_N <= 1'h1;
            O_HALFWORD_ADDRESS_LINE <= 1'h1;
         end else if (nxt_state == `SBSU_ST_ADDR) begin
            O_CS_N <= I_REQ_CS_N;
            O_ADDR <= I_REQ_ADDR;
            O_IO_SPACE <= I_REQ_IO;
            O_WRITE <= I_REQ_WRITE;
            O_BE0_N <= lane_be_n[0];
            O_BE1_N <= lane_be_n[1];
            O_BE2_HBE_N <= lane_bh_n;
            O_HALFWORD_ADDRESS_LINE <= lane_a1;
         end else begin
            O_BE0_N <= lane_be_n[0];
            O_BE1_N <= lane_be_n[1];
            O_BE2_HBE_N <= lane_bh_n;
            O_HALFWORD_ADDRESS_LINE <= lane_a1;
            // Aligned bursts make bits 3:2 the word index of the beat
            O_ADDR <= {addr_ff[31:4],
                       (size_ff == `SBSU_SZ_BURST) ? nxt_beat[2:1] : addr_ff[3:2],
                       lane_a1, addr_ff[0]};
         end
         O_DATA[31:16] <= 16'h0000;
         O_DATA_OE[31:16] <= 16'h0000;
         if (nxt_state == `SBSU_ST_HOLD) begin
            O_DATA_OE[15:0] <= 16'h0000;
         end else if (nxt_state != `SBSU_ST_IDLE && nxt_state != `SBSU_ST_ADDR &&
                      write_ff) begin
            O_DATA[15:0] <= wr_half;
            O_DATA_OE[15:0] <= 16'hFFFF;
         end else if (nxt_state == `SBSU_ST_ADDR) begin
            if (sel_write && sel_size != `SBSU_SZ_BURST) begin
               O_DATA[15:0] <= wr_half;
               O_DATA_OE[15:0] <= 16'hFFFF;
            end else begin
               O_DATA_OE[15:0] <= 16'h0000;
            end
         end else if (~write_ff) begin
            O_DATA_OE[15:0] <= 16'h0000;
         end
      end
   end
endmodule // sbsu_top

/* File: tb/sbsu_chk.sv */
`timescale 1ns/10ps
// ------
// Port checker
// ------
module sbsu_chk (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic [1:0] I_REQ_SIZE,
   input wire logic [31:0] I_REQ_ADDR,
   input wire logic I_REQ_WRITE,
   input wire logic I_REQ_IO,
   input wire logic [3:0] I_REQ_CS_N,
   input wire logic I_HOLD_REQ_N,
   input wire logic O_REQ_ACK,
   input wire logic O_RD_VALID,
   input wire logic O_REJECT,
   input wire logic O_WIDTH16,
   input wire logic O_BE0_N,
   input wire logic O_BE1_N,
   input wire logic O_BE2_HBE_N,
   input wire logic O_HALFWORD_ADDRESS_LINE,
   input wire logic O_CYC_START_N,
   input wire logic [3:0] O_CS_N,
   input wire logic O_IO_SPACE,
   input wire logic [31:0] O_ADDR,
   input wire logic [31:0] O_DATA_OE,
   input wire logic O_HOLD_ACK_N
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);
   // Cycles of unbroken hold request; a slow burst still ends well under 40
   logic [5:0] hcnt_ff;
   always @(posedge I_CLK) begin
      if (!I_RST_B || I_HOLD_REQ_N)
         hcnt_ff <= 6'h0;
      else if (hcnt_ff != 6'h3F)
         hcnt_ff <= hcnt_ff + 6'h1;
   end
   chk_upper_float:
      assert property (O_DATA_OE[31:16] == 16'h0) else $error("upper lines driven");
   chk_width_kept:
      assert property ($past(I_RST_B) |-> O_WIDTH16 && $stable(O_WIDTH16))
         else $error("bus width changed");
   chk_strobe_single:
      assert property (!O_CYC_START_N |=> O_CYC_START_N) else $error("long strobe");
   chk_ack_start:
      assert property (O_REQ_ACK |-> !O_CYC_START_N) else $error("ack without strobe");
   chk_narrow_lanes:
      assert property (!O_CYC_START_N && O_BE2_HBE_N |-> O_HALFWORD_ADDRESS_LINE == I_REQ_ADDR[1]
         && O_BE0_N == (I_REQ_SIZE == 2'h0 && I_REQ_ADDR[0])
         && O_BE1_N == (I_REQ_SIZE == 2'h0 && !I_REQ_ADDR[0])) else $error("narrow lanes");
   chk_wide_lanes:
      assert property (!O_CYC_START_N && !O_BE2_HBE_N |-> !O_BE0_N && !O_BE1_N && !O_HALFWORD_ADDRESS_LINE
         ##1 !O_HALFWORD_ADDRESS_LINE) else $error("wide lanes");
   chk_read_idle:
      assert property (O_RD_VALID |-> O_CYC_START_N) else $error("read not followed by idle");
   chk_reject_quiet:
      assert property (O_REJECT |-> O_CYC_START_N && !O_REQ_ACK) else $error("refused cycle ran");
   chk_hold_quiet:
      assert property (!O_HOLD_ACK_N && !I_HOLD_REQ_N |-> O_CYC_START_N)
         else $error("cycle during hold");
   chk_hold_exit:
      assert property (!O_HOLD_ACK_N && I_HOLD_REQ_N |-> ##[1:3] O_HOLD_ACK_N)
         else $error("hold not left");
   chk_hold_grant:
      assert property (hcnt_ff == 6'h28 |-> !O_HOLD_ACK_N) else $error("hold not granted");
   chk_start_fields:
      assert property (!O_CYC_START_N |-> O_CS_N == I_REQ_CS_N && O_IO_SPACE == I_REQ_IO
         && O_ADDR == I_REQ_ADDR) else $error("start fields wrong");
   chk_start_wdata:
      assert property (!O_CYC_START_N |-> O_DATA_OE[15:0] ==
         ((I_REQ_WRITE && I_REQ_SIZE != 2'h3) ? 16'hFFFF : 16'h0000))
         else $error("start data wrong");
   cover property (!O_CYC_START_N && !O_BE2_HBE_N);
   cover property (O_REJECT);
   cover property ($fell(O_HOLD_ACK_N));
   cover property (O_RD_VALID);
endmodule // sbsu_chk

bind sbsu_top sbsu_chk u_chk (.*);

/* File: tb/sbsu_mem.sv */
`timescale 1ns/10ps
// ------
// Far-side memory with set wait
// ------
module sbsu_mem (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_cyc_start_n,
   input wire logic i_write,
   input wire logic [31:0] i_addr,
   input wire logic [19:0] i_pins,
   input wire logic [3:0] i_n_xfer,
   input wire logic [1:0] i_wait,
   output wire logic o_ready_n,
   output wire logic [31:0] o_data
);
   reg [3:0] left_ff;
   reg [3:0] idx_ff;
   reg [1:0] wcnt_ff;
   reg [7:0] base_ff;
   reg [31:0] last_ff = 32'h0;
   reg [19:0] rec [0:7];
   wire rdy = (left_ff != 4'h0) && (wcnt_ff == i_wait);
   assign o_ready_n = ~rdy;
   // Lines show the inverse of the last value when idle, so stale data never matches
   assign o_data = (rdy && !i_write) ? {16'h5A5A, 5'h15, idx_ff[2:0], base_ff} : ~last_ff;
   always @(posedge i_clk) begin
      last_ff <= o_data;
      if (!i_rst_b) begin
         left_ff <= 4'h0;
         idx_ff <= 4'h0;
         wcnt_ff <= 2'h0;
      end else if (!i_cyc_start_n) begin
         left_ff <= i_n_xfer;
         idx_ff <= 4'h0;
         wcnt_ff <= 2'h0;
         base_ff <= {i_addr[7:2], 2'h2};
      end else if (rdy) begin
         rec[idx_ff[2:0]] <= i_pins;
         idx_ff <= idx_ff + 4'h1;
         left_ff <= left_ff - 4'h1;
         wcnt_ff <= 2'h0;
      end else if (left_ff != 4'h0) begin
         wcnt_ff <= wcnt_ff + 2'h1;
      end
   end
endmodule // sbsu_mem

/* File: tb/sbsu_top_bench.sv */
`timescale 1ns/10ps
module sbsu_top_bench;
   // ------
   // Stimulus
   // ------
   reg I_CLK = 1'b0;
   reg I_RST_B = 1'b0;
   reg I_WIDTH16 = 1'b1;
   reg I_REQ = 1'b0;
   reg I_REQ_WRITE = 1'b0;
   reg I_REQ_IO = 1'b0;
   reg I_REQ_LOCK = 1'b0;
   reg I_HOLD_REQ_N = 1'b1;
   reg [1:0] I_REQ_SIZE = 2'h0;
   reg [31:0] I_REQ_ADDR = 32'h0;
   reg [127:0] I_REQ_WDATA = 128'h0;
   reg [3:0] I_REQ_CS_N = 4'hE;
   reg [1:0] mem_wait = 2'h0;
   reg [3:0] n_xfer = 4'h1;
   wire I_READY_N;
   wire [31:0] I_DATA;
   wire O_REQ_ACK, O_RD_VALID, O_REJECT, O_WIDTH16, O_BE0_N, O_BE1_N, O_BE2_HBE_N, O_HALFWORD_ADDRESS_LINE;
   wire O_CYC_START_N, O_IO_SPACE, O_WRITE, O_HOLD_ACK_N;
   wire [31:0] O_RD_DATA, O_ADDR, O_DATA, O_DATA_OE;
   wire [3:0] O_CS_N;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int nstb = 0;
   bit hold_mid = 1'b0;
   reg [31:0] rdq [$];
   // size, write, wait, address, data
   localparam logic [44:0] ROWS [0:13] = '{
      {2'h0, 1'b0, 2'h0, 8'h34, 32'h0}, {2'h0, 1'b0, 2'h1, 8'h35, 32'h0},
      {2'h0, 1'b0, 2'h0, 8'h36, 32'h0}, {2'h0, 1'b0, 2'h2, 8'h37, 32'h0},
      {2'h1, 1'b0, 2'h0, 8'h40, 32'h0}, {2'h1, 1'b0, 2'h1, 8'h42, 32'h0},
      {2'h2, 1'b0, 2'h2, 8'h48, 32'h0}, {2'h3, 1'b0, 2'h1, 8'h50, 32'h0},
      {2'h0, 1'b1, 2'h0, 8'h61, 32'h0000A5C3}, {2'h0, 1'b1, 2'h1, 8'h62, 32'h00003C96},
      {2'h1, 1'b1, 2'h0, 8'h66, 32'h12345678}, {2'h1, 1'b1, 2'h2, 8'h44, 32'h56789ABC},
      {2'h2, 1'b1, 2'h1, 8'h68, 32'hCAFE1357}, {2'h3, 1'b1, 2'h2, 8'h70, 32'h11112222}};
   always #4 I_CLK = ~I_CLK;
   sbsu_top u_dut (.*);
   sbsu_mem u_mem (.i_clk(I_CLK), .i_rst_b(I_RST_B), .i_cyc_start_n(O_CYC_START_N),
      .i_write(O_WRITE), .i_addr(O_ADDR), .i_n_xfer(n_xfer), .i_wait(mem_wait),
      .i_pins({O_HALFWORD_ADDRESS_LINE, O_BE2_HBE_N, O_BE1_N, O_BE0_N, O_DATA[15:0]}),
      .o_ready_n(I_READY_N), .o_data(I_DATA));
   always @(posedge I_CLK) begin
      cyc++;
      if (O_RD_VALID === 1'b1)
         rdq.push_back(O_RD_DATA);
      if (O_CYC_START_N === 1'b0)
         nstb++;
      if (cyc == 3000) begin
         n_errors++;
         print_verdict();
      end
   end
   // ------
   // Tasks
   // ------
   task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task print_verdict;
      if (n_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic [15:0] pd(input [2:0] k, input [7:0] a);
      pd = {5'h15, k, a[7:2], 2'h2};
   endfunction
   function automatic [3:0] lanes(input [1:0] sz, input [7:0] a, input [2:0] k);
      if (sz[1])
         lanes = {k[0], 3'h0};
      else
         lanes = {a[1], 1'b1, sz[0] ? 2'h0 : (a[0] ? 2'h1 : 2'h2)};
   endfunction
   task automatic run(input [44:0] r);
      reg [1:0] sz;
      reg [7:0] a;
      reg [127:0] wd;
      reg [31:0] w;
      reg [15:0] dm;
      reg [15:0] ev;
      int n;
      int i;
      sz = r[44:43];
      a = r[39:32];
      wd = {r[31:0] + 32'h3, r[31:0] + 32'h2, r[31:0] + 32'h1, r[31:0]};
      n = (sz == 2'h3) ? 8 : (sz == 2'h2) ? 2 : 1;
      dm = r[42] ? ((sz != 2'h0) ? 16'hFFFF : (a[0] ? 16'hFF00 : 16'h00FF)) : 16'h0;
      @(posedge I_CLK);
      I_REQ <= 1'b1;
      I_REQ_WRITE <= r[42];
      I_REQ_SIZE <= sz;
      I_REQ_ADDR <= {24'h001000, a};
      I_REQ_WDATA <= wd;
      mem_wait <= r[41:40];
      n_xfer <= n[3:0];
      i = 0;
      do begin
         @(posedge I_CLK);
         i++;
      end while (O_REQ_ACK !== 1'b1 && i < 40);
      I_REQ <= 1'b0;
      if (hold_mid)
         I_HOLD_REQ_N <= 1'b0;
      do begin
         @(posedge I_CLK);
         i++;
      end while (u_mem.idx_ff != n && i < 120);
      repeat (3) @(posedge I_CLK);
      for (i = 0; i < n; i++) begin
         ev = (sz == 2'h0) ? {2{wd[7:0]}} : (sz == 2'h1) ? wd[16*a[1] +: 16] : wd[16*i +: 16];
         chk("lanes", {lanes(sz, a, i[2:0]), ev & dm},
            {u_mem.rec[i][19:16], u_mem.rec[i][15:0] & dm});
      end
      if (!r[42]) begin
         chk("reads", sz[0] && sz[1] ? 4 : 1, rdq.size());
         w = {pd(3'h1, a), pd(3'h0, a)};
         if (sz == 2'h0)
            w = {24'h0, a[0] ? w[15:8] : w[7:0]};
         if (sz == 2'h1)
            w = {16'h0, w[15:0]};
         for (i = 0; rdq.size() > 0; i++)
            chk("rdata", sz[1] ? {pd(3'(2*i+1), a), pd(3'(2*i), a)} : w, rdq.pop_front());
      end
   endtask
   // ------
   // Sequence
   // ------
   initial begin
      int i;
      int k;
      repeat (5) @(posedge I_CLK);
      I_RST_B <= 1'b1;
      @(posedge I_CLK);
      chk("strobe", 1, O_CYC_START_N);
      chk("selects", 4'hF, O_CS_N);
      chk("hold_ack", 1, O_HOLD_ACK_N);
      chk("width", 1, O_WIDTH16);
      chk("upper_oe", 0, O_DATA_OE[31:16]);
      foreach (ROWS[j])
         run(ROWS[j]);
      // Second byte write kept pending starts right after the first ends
      @(posedge I_CLK);
      I_REQ <= 1'b1;
      I_REQ_WRITE <= 1'b1;
      I_REQ_SIZE <= 2'h0;
      I_REQ_ADDR <= 32'h00100200;
      mem_wait <= 2'h0;
      n_xfer <= 4'h1;
      for (int j = 0; j < 2; j++) begin
         i = 0;
         do begin
            @(posedge I_CLK);
            i++;
         end while (O_REQ_ACK !== 1'b1 && i < 20);
      end
      I_REQ <= 1'b0;
      chk("restart_gap", 2, i);
      repeat (4) @(posedge I_CLK);
      // Burst to I/O space, then a burst off a 16-byte boundary
      for (int j = 0; j < 2; j++) begin
         k = nstb;
         @(posedge I_CLK);
         I_REQ <= 1'b1;
         I_REQ_SIZE <= 2'h3;
         I_REQ_IO <= (j == 0);
         I_REQ_ADDR <= (j == 0) ? 32'h00100100 : 32'h00100108;
         i = 0;
         do begin
            @(posedge I_CLK);
            i++;
         end while (O_REJECT !== 1'b1 && i < 20);
         I_REQ <= 1'b0;
         I_REQ_IO <= 1'b0;
         chk("reject", 1, O_REJECT);
         repeat (4) @(posedge I_CLK);
         chk("no_cycle", k, nstb);
      end
      // hold while idle; the request waits it out
      I_HOLD_REQ_N <= 1'b0;
      repeat (45) @(posedge I_CLK);
      chk("hold_ack", 0, O_HOLD_ACK_N);
      fork
         begin
            repeat (6) @(posedge I_CLK);
            I_HOLD_REQ_N <= 1'b1;
         end
      join_none
      run(ROWS[1]);
      // hold raised once a word read is under way
      hold_mid = 1'b1;
      run(ROWS[6]);
      chk("hold_ack", 0, O_HOLD_ACK_N);
      I_HOLD_REQ_N <= 1'b1;
      hold_mid = 1'b0;
      repeat (5) @(posedge I_CLK);
      chk("hold_ack", 1, O_HOLD_ACK_N);
      print_verdict();
   end
endmodule // sbsu_top_bench
